// ===== design/jtag_engine_consts.vh
// shared constants of the byte command engine: field positions,
// opcodes, sizes and reset levels.
// assumes inclusion by bare name from the engine's design files.
`ifndef JTAG_ENGINE_CONSTS_VH
`define JTAG_ENGINE_CONSTS_VH

// command byte layout
`define CMD_W           8
`define CMD_KIND_BIT    7
`define OPC_HI          7
`define OPC_LO          5
`define OPC_SCAN        3'h4
`define TMS_TDI_BIT     6
`define TMS_PAY_HI      5
`define TMS_MAX_BITS    3'h5

// scan opcode flag positions
`define SC_LAST_TMS_BIT 3
`define SC_CAP_BIT      2
`define SC_TDI_BIT      1
`define SC_FIX_BIT      0

// length byte layout
`define LEN_PACKED_BIT  7
`define LEN_HI          6

// counters
`define REM_W           8
`define CHUNK_W         4
`define BITS_PER_BYTE   4'h8
`define CAP_N_W         3
`define CAP_N_LAST      3'h7

// response buffer
`define BUF_DEPTH       2'h2

// pin levels after reset
`define TMS_RST         1'b0
`define TDI_RST         1'b0

`endif

// ===== design/jtag_pin_sync.v
// three-stage synchroniser with agreement filter for one pin.
// assumes the input is asynchronous to i_clk and slower than it.
`default_nettype none

module jtag_pin_sync
(
    input  wire i_clk,      // block clock
    input  wire i_rst,      // async reset, active high
    input  wire i_pin,      // raw pin level
    output reg  o_lvl_q     // filtered level
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    ////////////////////////////////////////////////////////////////////////
    // the first stage feeds only the second; a change is accepted
    // only once the last two stages agree, so one odd sample is ignored
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_q    <= 1'b0;
            s2_q    <= 1'b0;
            s3_q    <= 1'b0;
            o_lvl_q <= 1'b0;
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                o_lvl_q <= s3_q;
        end
    end

endmodule

`default_nettype wire

// ===== design/jtag_rsp_buffer.v
// two-entry buffer with valid/ready on both sides.
// assumes one clock; head entry is a flop so out data is registered.
`default_nettype none
`include "jtag_engine_consts.vh"

module jtag_rsp_buffer #(
    parameter W = 8
)
(
    input  wire         i_clk,       // block clock
    input  wire         i_rst,       // async reset, active high
    input  wire         i_in_valid,  // word offered
    output wire         o_in_ready,  // room for a word
    input  wire [W-1:0] i_in_data,   // offered word
    output wire         o_out_valid, // head word valid
    input  wire         i_out_ready, // sink takes head
    output wire [W-1:0] o_out_data   // head word
);

    reg [W-1:0] e0_q;
    reg [W-1:0] e1_q;
    reg [1:0]   cnt_q;
    wire        push;
    wire        pop;

    // honest full/empty from the occupancy count
    assign o_in_ready  = (cnt_q != `BUF_DEPTH);
    assign o_out_valid = (cnt_q != 2'h0);
    assign o_out_data  = e0_q;
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    ////////////////////////////////////////////////////////////////////////
    // head shifts forward on pop so the output never needs a mux
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            e0_q  <= {W{1'b0}};
            e1_q  <= {W{1'b0}};
            cnt_q <= 2'h0;
        end
        else
        begin
            if (pop)
                e0_q <= e1_q;
            if (push)
            begin
                if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
                    e0_q <= i_in_data;
                else
                    e1_q <= i_in_data;
            end
            if (push && !pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop && !push)
                cnt_q <= cnt_q - 2'h1;
        end
    end

endmodule

`default_nettype wire

// ===== design/jtag_byte_command_engine.v
// byte command engine: decodes command bytes and drives a scan port.
// assumes i_tck is a free-running reference from outside; the block
// presents one bit per tck cycle and flags it on o_CYCLE_ACT so the
// port logic can gate tck while the engine waits for bytes.
//
// Overview of operation
// - bit7 clear: TMS packet, bit6 TDI
// - marker above payload sets TMS bit count
// - TDI held at bit6 through TMS packet
// - TMS bits sent LSB first, one per cycle
// - scan packet: opcode, length, up to sixteen data
// - top bits 100 start scan; low nibble subtype
// - opcode bit3 gives TMS on last cycle
// - earlier scan cycles drive TMS low
// - capture flag set: TDO sampled into responses
// - fixed-input flag: bit1 holds TDI level
// - bit0 fixed-input flag; else TDI from data
// - normal length: bits 6..0 plus one
// - normal length: data bytes unless fixed input
// - packed length byte ends two-byte packet
// - highest set bit 6..1 marks packed length
// - packed data bit0 drives first TDI cycle
// - packed with fixed input: length only
// - TMS packet one to five bits, no capture
// - data bytes LSB first, zero padded
// - TDO bytes packed, pushed, scan stalls when full
// - top bits 101/110/111 reserved, dropped
`default_nettype none
`include "jtag_engine_consts.vh"

module jtag_byte_command_engine
(
    input  wire              I_CLK,        // block clock, 125 MHz
    input  wire              I_SYS_RST,    // async reset, active high
    input  wire [`CMD_W-1:0] I_CMD_DATA,   // command fifo byte
    input  wire              I_CMD_VALID,  // command byte present
    output wire              O_CMD_READY,  // engine takes byte
    output wire [`CMD_W-1:0] O_RSP_DATA,   // captured tdo byte
    output wire              O_RSP_VALID,  // response byte present
    input  wire              I_RSP_READY,  // response fifo takes byte
    input  wire              I_TCK,        // scan clock reference
    input  wire              I_TDO,        // scan data from chain
    output reg               O_TMS,        // scan mode select
    output reg               O_TDI,        // scan data to chain
    output reg               O_CYCLE_ACT,  // this tck cycle carries a bit
    output wire              O_BUSY,       // packet in progress
    output reg               O_RSV_CMD     // reserved byte dropped, pulse
);

    // producer states
    localparam [1:0] S_OP   = 2'h0;
    localparam [1:0] S_LEN  = 2'h1;
    localparam [1:0] S_DATA = 2'h2;
    localparam [1:0] S_RUN  = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // index of highest set bit among 6..1, zero when none
    function [2:0] marker_pos;
        input [6:0] b;
        begin
            if (b[6])
                marker_pos = 3'h6;
            else if (b[5])
                marker_pos = 3'h5;
            else if (b[4])
                marker_pos = 3'h4;
            else if (b[3])
                marker_pos = 3'h3;
            else if (b[2])
                marker_pos = 3'h2;
            else if (b[1])
                marker_pos = 3'h1;
            else
                marker_pos = 3'h0;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire tck_lvl;
    wire tdo_lvl;
    reg  tck_prev_q;
    wire tck_rise;
    wire tck_fall;

    jtag_pin_sync u_tck_sync
    (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .i_pin   (I_TCK),
        .o_lvl_q (tck_lvl)
    );

    jtag_pin_sync u_tdo_sync
    (
        .i_clk   (I_CLK),
        .i_rst   (I_SYS_RST),
        .i_pin   (I_TDO),
        .o_lvl_q (tdo_lvl)
    );

    // edges of the filtered tck level
    assign tck_rise = tck_lvl && !tck_prev_q;
    assign tck_fall = !tck_lvl && tck_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // producer state and its next values
    reg [1:0]          st_q;
    reg [1:0]          st_d;
    reg [`REM_W-1:0]   rem_q;
    reg [`REM_W-1:0]   rem_d;
    reg [`CHUNK_W-1:0] chunk_q;
    reg [`CHUNK_W-1:0] chunk_d;
    reg [`CMD_W-1:0]   src_q;
    reg [`CMD_W-1:0]   src_d;
    reg                tmsmode_q;
    reg                tmsmode_d;
    reg                last_tms_q;
    reg                last_tms_d;
    reg                cap_en_q;
    reg                cap_en_d;
    reg                tdi_val_q;
    reg                tdi_val_d;
    reg                fix_q;
    reg                fix_d;
    reg                rsv_d;
    reg                fill;
    reg [2:0]          pos;

    // next-bit slot, handed to the tck side
    reg nxt_v_q;
    reg nxt_tms_q;
    reg nxt_tdi_q;
    reg nxt_cap_q;
    reg nxt_last_q;
    reg bit_tms;
    reg bit_tdi;

    // active bit and tdo packing
    reg                 act_cap_q;
    reg                 act_last_q;
    reg [`CMD_W-1:0]    cap_q;
    reg [`CAP_N_W-1:0]  cap_n_q;
    reg                 rsp_pend_q;
    reg [`CMD_W-1:0]    rsp_byte_q;
    wire [`CMD_W-1:0]   tdo_word;
    wire [`CMD_W-1:0]   cap_full;
    wire                buf_ready;
    wire                take;
    wire                cmd_take;

    // bytes are taken in order, only while the producer is not in S_RUN
    assign O_CMD_READY = (st_q != S_RUN);
    assign cmd_take    = I_CMD_VALID && O_CMD_READY;
    // a new bit may go out only while no response byte is waiting
    assign take        = tck_fall && nxt_v_q && !rsp_pend_q;
    assign O_BUSY      = (st_q != S_OP) || nxt_v_q || O_CYCLE_ACT
                         || rsp_pend_q;

    ////////////////////////////////////////////////////////////////////////
    // levels for the bit about to be queued
    always @*
    begin
        if (tmsmode_q)
        begin
            bit_tms = src_q[0];
            bit_tdi = tdi_val_q;
        end
        else
        begin
            // earlier cycles low, last cycle from opcode
            bit_tms = (rem_q == 8'h01) ? last_tms_q : 1'b0;
            // fixed level or data bit, lsb first
            bit_tdi = fix_q ? tdi_val_q : src_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command decode and bit producer
    always @*
    begin
        st_d       = st_q;
        rem_d      = rem_q;
        chunk_d    = chunk_q;
        src_d      = src_q;
        tmsmode_d  = tmsmode_q;
        last_tms_d = last_tms_q;
        cap_en_d   = cap_en_q;
        tdi_val_d  = tdi_val_q;
        fix_d      = fix_q;
        rsv_d      = 1'b0;
        fill       = 1'b0;
        pos        = 3'h0;
        case (st_q)
            S_OP:
            begin
                if (cmd_take)
                begin
                    if (!I_CMD_DATA[`CMD_KIND_BIT])
                    begin
                        // marker above payload gives the bit count
                        pos = marker_pos({1'b0, I_CMD_DATA[`TMS_PAY_HI:0]});
                        if (pos != 3'h0 && pos <= `TMS_MAX_BITS)
                        begin
                            tmsmode_d = 1'b1;
                            tdi_val_d = I_CMD_DATA[`TMS_TDI_BIT];
                            src_d     = I_CMD_DATA;
                            rem_d     = {5'h00, pos};
                            chunk_d   = {1'b0, pos};
                            st_d      = S_RUN;
                        end
                    end
                    else if (I_CMD_DATA[`OPC_HI:`OPC_LO] == `OPC_SCAN)
                    begin
                        tmsmode_d  = 1'b0;
                        last_tms_d = I_CMD_DATA[`SC_LAST_TMS_BIT];
                        cap_en_d   = I_CMD_DATA[`SC_CAP_BIT];
                        tdi_val_d  = I_CMD_DATA[`SC_TDI_BIT];
                        fix_d      = I_CMD_DATA[`SC_FIX_BIT];
                        st_d       = S_LEN;
                    end
                    else
                    begin
                        rsv_d = 1'b1;
                    end
                end
            end
            S_LEN:
            begin
                if (cmd_take)
                begin
                    if (!I_CMD_DATA[`LEN_PACKED_BIT])
                    begin
                        // normal format: field holds length minus one
                        rem_d   = {1'b0, I_CMD_DATA[`LEN_HI:0]} + 8'h01;
                        chunk_d = `BITS_PER_BYTE;
                        st_d    = fix_q ? S_RUN : S_DATA;
                    end
                    else
                    begin
                        // packed: marker gives length, data below it
                        pos = marker_pos(I_CMD_DATA[`LEN_HI:0]);
                        if (pos == 3'h0)
                        begin
                            st_d = S_OP;
                        end
                        else
                        begin
                            src_d   = I_CMD_DATA;
                            rem_d   = {5'h00, pos};
                            chunk_d = {1'b0, pos};
                            st_d    = S_RUN;
                        end
                    end
                end
            end
            S_DATA:
            begin
                if (cmd_take)
                begin
                    // lsb of each data byte goes first
                    src_d   = I_CMD_DATA;
                    chunk_d = `BITS_PER_BYTE;
                    st_d    = S_RUN;
                end
            end
            S_RUN:
            begin
                if (!nxt_v_q)
                begin
                    fill    = 1'b1;
                    src_d   = src_q >> 1;
                    rem_d   = rem_q - 8'h01;
                    chunk_d = chunk_q - 4'h1;
                    if (rem_q == 8'h01)
                        st_d = S_OP;
                    else if (chunk_q == 4'h1 && !fix_q && !tmsmode_q)
                        st_d = S_DATA;
                end
            end
            default:
            begin
                st_d = S_OP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // producer registers
    always @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            st_q       <= S_OP;
            rem_q      <= 8'h00;
            chunk_q    <= 4'h0;
            src_q      <= 8'h00;
            tmsmode_q  <= 1'b0;
            last_tms_q <= 1'b0;
            cap_en_q   <= 1'b0;
            tdi_val_q  <= 1'b0;
            fix_q      <= 1'b0;
            O_RSV_CMD  <= 1'b0;
        end
        else
        begin
            st_q       <= st_d;
            rem_q      <= rem_d;
            chunk_q    <= chunk_d;
            src_q      <= src_d;
            tmsmode_q  <= tmsmode_d;
            last_tms_q <= last_tms_d;
            cap_en_q   <= cap_en_d;
            tdi_val_q  <= tdi_val_d;
            fix_q      <= fix_d;
            O_RSV_CMD  <= rsv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next-bit slot: filled by the producer, emptied at a tck fall.
    // the slot is refilled within a few clocks, far inside one tck
    // period, so bits of one packet and the next stay back to back
    always @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            nxt_v_q    <= 1'b0;
            nxt_tms_q  <= 1'b0;
            nxt_tdi_q  <= 1'b0;
            nxt_cap_q  <= 1'b0;
            nxt_last_q <= 1'b0;
        end
        else if (fill)
        begin
            nxt_v_q    <= 1'b1;
            nxt_tms_q  <= bit_tms;
            nxt_tdi_q  <= bit_tdi;
            nxt_cap_q  <= cap_en_q && !tmsmode_q;
            nxt_last_q <= (rem_q == 8'h01);
        end
        else if (take)
        begin
            nxt_v_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive: new levels change on the falling edge so the chain
    // samples them stable on the rising edge; idle cycles hold levels
    always @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            tck_prev_q  <= 1'b0;
            O_TMS       <= `TMS_RST;
            O_TDI       <= `TDI_RST;
            O_CYCLE_ACT <= 1'b0;
            act_cap_q   <= 1'b0;
            act_last_q  <= 1'b0;
        end
        else
        begin
            tck_prev_q <= tck_lvl;
            if (take)
            begin
                O_TMS       <= nxt_tms_q;
                O_TDI       <= nxt_tdi_q;
                O_CYCLE_ACT <= 1'b1;
                act_cap_q   <= nxt_cap_q;
                act_last_q  <= nxt_last_q;
            end
            else if (tck_fall)
            begin
                // no bit ready or a response byte waiting: stall, flagged for tck gating
                O_CYCLE_ACT <= 1'b0;
                act_cap_q   <= 1'b0;
                act_last_q  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tdo packing: bit n of the scan lands in bit n mod 8, upper bits
    // of a short last byte stay zero
    assign tdo_word = {{(`CMD_W-1){1'b0}}, tdo_lvl} << cap_n_q;
    assign cap_full = cap_q | tdo_word;

    always @(posedge I_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            cap_q      <= 8'h00;
            cap_n_q    <= 3'h0;
            rsp_pend_q <= 1'b0;
            rsp_byte_q <= 8'h00;
        end
        else
        begin
            if (tck_rise && O_CYCLE_ACT && act_cap_q)
            begin
                if (cap_n_q == `CAP_N_LAST || act_last_q)
                begin
                    rsp_pend_q <= 1'b1;
                    rsp_byte_q <= cap_full;
                    cap_q      <= 8'h00;
                    cap_n_q    <= 3'h0;
                end
                else
                begin
                    cap_q   <= cap_full;
                    cap_n_q <= cap_n_q + 3'h1;
                end
            end
            else if (rsp_pend_q && buf_ready)
            begin
                rsp_pend_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response buffer: absorbs a short receiver stall; when it fills
    // the pending byte holds and the scan waits
    jtag_rsp_buffer #(
        .W (`CMD_W)
    ) u_rsp_buf
    (
        .i_clk       (I_CLK),
        .i_rst       (I_SYS_RST),
        .i_in_valid  (rsp_pend_q),
        .o_in_ready  (buf_ready),
        .i_in_data   (rsp_byte_q),
        .o_out_valid (O_RSP_VALID),
        .i_out_ready (I_RSP_READY),
        .o_out_data  (O_RSP_DATA)
    );

endmodule

`default_nettype wire

// ===== verification/jtag_engine_chk_sva.sv
// checker for the byte command engine, seeing its top ports only.
// assumes one clock domain with the async active-high reset.
`default_nettype none

module jtag_engine_chk
(
    input wire logic       I_CLK,       // clock
    input wire logic       I_SYS_RST,   // reset
    input wire logic [7:0] I_CMD_DATA,  // cmd byte
    input wire logic       I_CMD_VALID, // offered
    input wire logic       O_CMD_READY, // taken
    input wire logic [7:0] O_RSP_DATA,  // rsp byte
    input wire logic       O_RSP_VALID, // rsp here
    input wire logic       I_RSP_READY, // rsp taken
    input wire logic       I_TCK,       // scan ref
    input wire logic       O_TMS,       // mode
    input wire logic       O_TDI,       // data out
    input wire logic       O_CYCLE_ACT, // bit cycle
    input wire logic       O_BUSY,      // pending
    input wire logic       O_RSV_CMD    // dropped
);
    timeunit 1ns;
    timeprecision 1ps;
    wire rsv_take;

    // a reserved top field taken from the command stream
    assign rsv_take = I_CMD_VALID && O_CMD_READY && (I_CMD_DATA[7:5] > 3'h4);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    ////////////////////////////////
    // pins only move just after a tck fall, never mid-cycle
    a_tms_edge: assert property (
        $changed(O_TMS) |-> !$past(I_TCK) && !$past(I_TCK, 2))
        else $error("tms moved away from a tck fall");
    a_tdi_edge: assert property (
        $changed(O_TDI) |-> !$past(I_TCK) && !$past(I_TCK, 2))
        else $error("tdi moved away from a tck fall");
    a_act_edge: assert property (
        O_CYCLE_ACT != $past(O_CYCLE_ACT) |-> $past(I_TCK, 3) == 1'b0)
        else $error("cycle flag moved away from a tck fall");
    // a stalled cycle must not disturb the chain
    a_idle_hold: assert property (
        !O_CYCLE_ACT |-> $stable(O_TMS) && $stable(O_TDI))
        else $error("pins moved in an idle cycle");
    a_rsp_hold: assert property (
        O_RSP_VALID && !I_RSP_READY |=> O_RSP_VALID && $stable(O_RSP_DATA))
        else $error("response lost while sink stalled");
    a_rsv_pulse: assert property (
        !O_BUSY && rsv_take |=> O_RSV_CMD)
        else $error("reserved opcode gave no pulse");
    a_rsv_cause: assert property (
        O_RSV_CMD |-> $past(rsv_take))
        else $error("drop pulse without a reserved byte");
    a_idle_ready: assert property (
        !O_BUSY |-> O_CMD_READY)
        else $error("idle engine refuses bytes");
    c_rsv: cover property (O_RSV_CMD);
    c_rsp: cover property (O_RSP_VALID && I_RSP_READY);
    c_stall: cover property (O_RSP_VALID && !I_RSP_READY ##1 O_RSP_VALID);
endmodule

bind jtag_byte_command_engine jtag_engine_chk u_jtag_engine_chk
(
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CMD_DATA(I_CMD_DATA),
    .I_CMD_VALID(I_CMD_VALID), .O_CMD_READY(O_CMD_READY), .O_RSP_DATA(O_RSP_DATA),
    .O_RSP_VALID(O_RSP_VALID), .I_RSP_READY(I_RSP_READY), .I_TCK(I_TCK),
    .O_TMS(O_TMS), .O_TDI(O_TDI), .O_CYCLE_ACT(O_CYCLE_ACT), .O_BUSY(O_BUSY),
    .O_RSV_CMD(O_RSV_CMD)
);
`default_nettype wire

// ===== verification/jtag_tap_model.sv
// scan partner: a one-bit bypass chain, and the free tck reference.
// tck runs free; capture is qualified by the cycle flag, so it only counts those.
`default_nettype none

module jtag_tap_model
(
    output var logic  o_tck, // scan ref
    input  wire logic i_tdi, // data in
    input  wire logic i_act, // bit cycle
    output var logic  o_tdo  // data out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cap_q;

    ////////////////////////////////
    // 80 ns reference, phase apart from the block clock
    initial
    begin
        o_tck = 1'b1;
        cap_q = 1'b1;
        o_tdo = 1'b1;
        #3;
        forever #40 o_tck = ~o_tck;
    end
    // single chain only, so captured data is defined
    always @(posedge o_tck)
        if (i_act)
            cap_q <= i_tdi;
    // update on the fall so tdo is settled at the next rise
    always @(negedge o_tck)
        o_tdo <= cap_q;
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// bench for the byte command engine: packet table, then hand cases.
// assumes the design, its checker and the scan partner compile first.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] b; int nb; int n; logic [15:0] ms; logic [15:0] di;} row_t;
    logic clk = 1'b0;
    logic rst, cmd_v, rsp_rdy, cmd_rdy, rsp_v, tck, tdo, tms, tdi, act, busy, rsv;
    logic [7:0] cmd, rsp;
    logic [31:0] tdiw = 32'h015A_C396;
    logic [31:0] rv = 32'hFFC5_41A0;
    logic [31:0] cap;
    logic q_tms[$];
    logic q_tdi[$];
    int fail_count = 0;
    int checked = 0;
    int rsv_n = 0;
    int k;
    int j;
    row_t rows[11];

    always #4 clk = ~clk;
    jtag_byte_command_engine u_jtag_byte_command_engine
    (
        .I_CLK(clk), .I_SYS_RST(rst), .I_CMD_DATA(cmd), .I_CMD_VALID(cmd_v),
        .O_CMD_READY(cmd_rdy), .O_RSP_DATA(rsp), .O_RSP_VALID(rsp_v),
        .I_RSP_READY(rsp_rdy), .I_TCK(tck), .I_TDO(tdo), .O_TMS(tms), .O_TDI(tdi),
        .O_CYCLE_ACT(act), .O_BUSY(busy), .O_RSV_CMD(rsv)
    );
    jtag_tap_model u_jtag_tap_model
    (
        .o_tck(tck), .i_tdi(tdi), .i_act(act), .o_tdo(tdo)
    );

    ////////////////////////////////
    // log each bit cycle at the tck rise, where the chain samples
    always @(posedge tck)
        if (act === 1'b1)
        begin
            q_tms.push_back(tms);
            q_tdi.push_back(tdi);
        end
    always @(posedge clk)
        if (rsv === 1'b1)
            rsv_n++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // offer a byte at a falling edge; left valid for back-to-back use
    task automatic send(input logic [7:0] b);
        int w;
        cmd = b;
        cmd_v = 1'b1;
        for (w = 0; w < 5000 && cmd_rdy !== 1'b1; w++)
            @(negedge clk);
        @(negedge clk);
    endtask
    // wait for n bit cycles, then let extra ones show before comparing
    task automatic expect_bits(input int n, input logic [31:0] ms, input logic [31:0] di);
        logic [31:0] gm;
        logic [31:0] gd;
        int w;
        gm = '0;
        gd = '0;
        for (w = 0; w < 20000 && q_tdi.size() < n; w++)
            @(negedge clk);
        repeat (40) @(negedge clk);
        for (w = 0; w < n && w < q_tdi.size(); w++)
        begin
            gm[w] = q_tms[w];
            gd[w] = q_tdi[w];
        end
        chk(q_tdi.size(), n);
        chk(gm, ms);
        chk(gd, di);
        q_tms.delete();
        q_tdi.delete();
    endtask
    task automatic test_done;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        cmd = 8'h00;
        cmd_v = 1'b0;
        rsp_rdy = 1'b0;
        rows = '{
            '{32'h0000_0046, 1, 2, 16'h0002, 16'h0003},
            '{32'h0000_0003, 1, 1, 16'h0001, 16'h0000},
            '{32'h0000_005B, 1, 4, 16'h000B, 16'h000F},
            '{32'h0000_0035, 1, 5, 16'h0015, 16'h0000},
            '{32'h0005_0288, 3, 3, 16'h0004, 16'h0005},
            '{32'h0000_0983, 2, 10, 16'h0000, 16'h03FF},
            '{32'h0000_9680, 2, 4, 16'h0000, 16'h0006},
            '{32'h0000_8F89, 2, 3, 16'h0004, 16'h0000},
            '{32'h01A5_0880, 4, 9, 16'h0000, 16'h01A5},
            '{32'h0000_EA88, 2, 6, 16'h0020, 16'h002A},
            '{32'h0000_008B, 2, 1, 16'h0001, 16'h0001}
        };
        repeat (8) @(negedge clk);
        chk({tms, tdi, act, rsv, rsp_v, busy, cmd_rdy}, 32'h0000_0001);
        rst = 1'b0;
        @(negedge clk);
        foreach (rows[r])
        begin
            for (k = 0; k < rows[r].nb; k++)
                send(rows[r].b[8*k+:8]);
            cmd_v = 1'b0;
            expect_bits(rows[r].n, rows[r].ms, rows[r].di);
        end
        chk(rsp_v, 1'b0);
        // reserved bytes around a tms byte lacking its marker
        for (k = 0; k < 4; k++)
            send(rv[8*k+:8]);
        cmd_v = 1'b0;
        repeat (40) @(negedge clk);
        chk(rsv_n, 3);
        chk(q_tdi.size(), 0);
        // 25-bit capture scan after a tms bit, sink stalled until the scan waits, then drained
        send(8'h43);
        send(8'h84);
        send(8'h18);
        for (k = 0; k < 4; k++)
            send(tdiw[8*k+:8]);
        cmd_v = 1'b0;
        repeat (3000) @(negedge clk);
        chk(q_tdi.size(), 25);
        cap = {tdiw[30:0], 1'b1} & 32'h01FF_FFFF;
        for (k = 0; k < 4; k++)
        begin
            for (j = 0; j < 3000 && rsp_v !== 1'b1; j++)
                @(negedge clk);
            chk(rsp, cap[8*k+:8]);
            rsp_rdy = 1'b1;
            @(negedge clk);
            rsp_rdy = 1'b0;
        end
        expect_bits(26, 32'h0000_0001, {tdiw[24:0], 1'b1});
        chk(rsp_v, 1'b0);
        test_done();
    end
    // far beyond the expected run; a hang ends as a failure
    initial
    begin
        #400_000;
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
